// >>> logic/pct_defines.svh
`ifndef PCT_DEFINES_SVH
`define PCT_DEFINES_SVH
// task-file command and feature codes
`define PCT_CMD_SET_FEATURES   8'hef
`define PCT_FEAT_EXT_POWER     8'h4a
// sector-number fields
`define PCT_SUB_LSB            0
`define PCT_SUB_MSB            3
`define PCT_SUB_TIMER          4'h2
`define PCT_SUB_STATE          4'h3
`define PCT_BIT_SAVE           4
`define PCT_BIT_ENABLE         5
`define PCT_BIT_UNITS          7
// timer range, in 100 ms units
`define PCT_TIMER_MAX          16'hffff
`define PCT_TIMER_MIN          16'h0000
`define PCT_MIN_PER_UNIT       16'h0258
// error and status bit positions
`define PCT_ERR_ABORT_BIT      2
`define PCT_STS_BUSY_BIT       7
`define PCT_STS_READY_BIT      6
`define PCT_STS_FAULT_BIT      5
`define PCT_STS_ERR_BIT        0
// power condition table
`define PCT_COND_COUNT         4
`define PCT_COND_IDX_W         2
`endif

// >>> logic/pct_pkg.sv
package pct_pkg;
  typedef enum logic [1:0] {PCT_IDLE, PCT_READ, PCT_EXEC, PCT_DONE} pct_state_e;
  typedef struct packed {
    logic [15:0] timer;
    logic        enabled;
  } pct_entry_s;
endpackage : pct_pkg

// >>> logic/pct_cond_mem.sv
`timescale 1ns/1ps
`include "pct_defines.svh"
module pct_cond_mem
  import pct_pkg::*;
(
  // clock and reset
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_n_in,
  // access
  input  wire logic [`PCT_COND_IDX_W-1:0]   idx_in,
  input  wire logic                         wr_in,
  input  wire pct_entry_s                   wdata_in,
  output      pct_entry_s                   rdata_out
);
  typedef struct packed {
    pct_entry_s [`PCT_COND_COUNT-1:0] mem;
    pct_entry_s                       rd;
  } pct_mem_s;
  pct_mem_s st_reg;
  pct_mem_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.rd = st_reg.mem[idx_in];
    if (wr_in)
    begin
      st_next.mem[idx_in] = wdata_in;
    end
    if (!rst_n_in)
    begin
      st_next = '0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    st_reg <= st_next;
  end

  assign rdata_out = st_reg.rd;
endmodule : pct_cond_mem

// >>> logic/pct_in_sync.sv
`timescale 1ns/1ps
module pct_in_sync
  import pct_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  // pin in, clean level out
  input  wire logic pin_in,
  output      logic level_out
);
  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
  } pct_sync_s;
  pct_sync_s st_reg;
  pct_sync_s st_next;

  // level moves only once stages two and three agree
  always_comb
  begin
    st_next = st_reg;
    st_next.sh = {st_reg.sh[1:0], pin_in};
    if (st_reg.sh[1] == st_reg.sh[2])
    begin
      st_next.lvl = st_reg.sh[2];
    end
    if (!rst_n_in)
    begin
      st_next = '0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    st_reg <= st_next;
  end

  assign level_out = st_reg.lvl;
endmodule : pct_in_sync

// >>> logic/pct_cmd.sv
`timescale 1ns/1ps
`include "pct_defines.svh"
module pct_cmd
  import pct_pkg::*;
(
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_n_in,
  // task-file command block, sampled on cmd_valid_in
  input  wire logic                        cmd_valid_in,
  input  wire logic [7:0]                  command_in,
  input  wire logic [7:0]                  feature_in,
  input  wire logic [7:0]                  sector_count_in,
  input  wire logic [7:0]                  sector_number_in,
  input  wire logic [7:0]                  cylinder_low_in,
  input  wire logic [7:0]                  cylinder_high_in,
  // device configuration
  input  wire logic                        extended_power_feature_in,
  input  wire logic [`PCT_COND_COUNT-1:0]  cond_supported_in,
  input  wire logic [`PCT_COND_COUNT-1:0]  cond_changeable_in,
  input  wire logic [`PCT_COND_COUNT-1:0]  cond_saveable_in,
  input  wire logic                        drive_ready_pin_in,
  // result
  output      logic [7:0]                  error_register_out,
  output      logic [7:0]                  status_register_out,
  output      logic                        cmd_done_out,
  // current and saved enables, one bit per condition
  output      logic [`PCT_COND_COUNT-1:0]  cur_enabled_out,
  output      logic [`PCT_COND_COUNT-1:0]  saved_enabled_out
);
  typedef struct packed {
    pct_state_e                   state;
    logic [7:0]                   cond;
    logic [7:0]                   secnum;
    logic [15:0]                  timer;
    logic                         is_timer;
    logic [7:0]                   err;
    logic [7:0]                   sts;
    logic                         done;
    logic [`PCT_COND_COUNT-1:0]   cur_en;
    logic [`PCT_COND_COUNT-1:0]   sav_en;
  } pct_cmd_s;
  pct_cmd_s st_reg;
  pct_cmd_s st_next;

  logic                        ready_lvl;
  logic [`PCT_COND_IDX_W-1:0]  idx;
  logic                        cur_wr;
  logic                        sav_wr;
  pct_entry_s                  cur_wdata;
  pct_entry_s                  sav_wdata;
  pct_entry_s                  cur_rdata;
  logic                        cond_ok;
  logic                        abort;
  logic                        save_req;
  logic                        en_req;
  logic [31:0]                 scaled;
  logic [15:0]                 clamped;
  logic                        new_en;

  // ready is a pin from outside the clock domain
  pct_in_sync u_ready_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .pin_in      (drive_ready_pin_in),
    .level_out   (ready_lvl)
  );

  // current and saved tables hold timer values per condition
  pct_cond_mem u_cur_mem (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .idx_in      (idx),
    .wr_in       (cur_wr),
    .wdata_in    (cur_wdata),
    .rdata_out   (cur_rdata)
  );

  pct_cond_mem u_sav_mem (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .idx_in      (idx),
    .wr_in       (sav_wr),
    .wdata_in    (sav_wdata),
    .rdata_out   ()
  );

  assign idx = st_reg.cond[`PCT_COND_IDX_W-1:0];

  always_comb
  begin
    cond_ok  = (st_reg.cond < 8'(`PCT_COND_COUNT)) && cond_supported_in[idx]
               && cond_changeable_in[idx];
    save_req = st_reg.secnum[`PCT_BIT_SAVE];
    en_req   = st_reg.secnum[`PCT_BIT_ENABLE];
    // minutes are rescaled to 100 ms units
    scaled   = st_reg.secnum[`PCT_BIT_UNITS] ? (32'(st_reg.timer) * 32'(`PCT_MIN_PER_UNIT))
                                             : 32'(st_reg.timer);
    if (scaled > 32'(`PCT_TIMER_MAX))
    begin
      clamped = `PCT_TIMER_MAX;
    end
    else if (scaled < 32'(`PCT_TIMER_MIN))
    begin
      clamped = `PCT_TIMER_MIN;
    end
    else
    begin
      clamped = scaled[15:0];
    end
    // abort causes for both subcommands; clamping leaves no unsupported value
    abort = !extended_power_feature_in || !cond_ok || (save_req && !cond_saveable_in[idx]);
    new_en = st_reg.is_timer ? (en_req && (clamped != 16'h0000)) : en_req;
  end

  always_comb
  begin
    st_next   = st_reg;
    st_next.done = 1'b0;
    cur_wr    = 1'b0;
    sav_wr    = 1'b0;
    // timer-loading writes the clamped value; state-only keeps the timer
    cur_wdata.timer   = st_reg.is_timer ? clamped : cur_rdata.timer;
    cur_wdata.enabled = new_en;
    // saved copy mirrors the new current setting
    sav_wdata = cur_wdata;
    st_next.sts[`PCT_STS_READY_BIT] = ready_lvl;
    case (st_reg.state)
      PCT_IDLE:
      begin
        // only set-features with the extended power feature is taken
        if (cmd_valid_in && command_in == `PCT_CMD_SET_FEATURES
            && feature_in == `PCT_FEAT_EXT_POWER)
        begin
          if (sector_number_in[`PCT_SUB_MSB:`PCT_SUB_LSB] == `PCT_SUB_TIMER
              || sector_number_in[`PCT_SUB_MSB:`PCT_SUB_LSB] == `PCT_SUB_STATE)
          begin
            st_next.cond     = sector_count_in;
            st_next.secnum   = sector_number_in;
            st_next.timer    = {cylinder_high_in, cylinder_low_in};
            st_next.is_timer = sector_number_in[`PCT_SUB_MSB:`PCT_SUB_LSB] == `PCT_SUB_TIMER;
            st_next.sts[`PCT_STS_BUSY_BIT] = 1'b1;
            st_next.state    = PCT_READ;
          end
        end
      end
      PCT_READ:
      begin
        // table read data settle for one cycle
        st_next.state = PCT_EXEC;
      end
      PCT_EXEC:
      begin
        if (!abort)
        begin
          cur_wr = 1'b1;
          // save request gates the saved copy
          sav_wr = save_req;
          st_next.cur_en[idx] = new_en;
          if (save_req)
          begin
            st_next.sav_en[idx] = new_en;
          end
        end
        // abort and error bits, busy and fault clear
        st_next.err[`PCT_ERR_ABORT_BIT]  = abort;
        st_next.sts[`PCT_STS_ERR_BIT]    = abort;
        st_next.sts[`PCT_STS_BUSY_BIT]   = 1'b0;
        st_next.sts[`PCT_STS_FAULT_BIT]  = 1'b0;
        st_next.done  = 1'b1;
        st_next.state = PCT_DONE;
      end
      PCT_DONE:
      begin
        st_next.state = PCT_IDLE;
      end
      default:
      begin
        st_next.state = PCT_IDLE;
      end
    endcase
    if (!rst_n_in)
    begin
      st_next = '0;
      st_next.state = PCT_IDLE;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    st_reg <= st_next;
  end

  assign error_register_out  = st_reg.err;
  assign status_register_out = st_reg.sts;
  assign cmd_done_out        = st_reg.done;
  assign cur_enabled_out     = st_reg.cur_en;
  assign saved_enabled_out   = st_reg.sav_en;

  // done comes with busy low and error matching abort bit
  chk_done_status: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_done_out |-> !status_register_out[7] && !status_register_out[5]
    && (status_register_out[0] == error_register_out[2]))
    else $error("done without clean status");
  chk_abort_frozen: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && abort)
    |=> $stable(cur_enabled_out) && $stable(saved_enabled_out))
    else $error("abort changed settings");
  chk_zero_disable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !abort && st_reg.is_timer && clamped == 16'h0000)
    |=> !cur_enabled_out[$past(idx)])
    else $error("zero timer enabled");
  chk_state_enable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !abort && !st_reg.is_timer)
    |=> cur_enabled_out[$past(idx)] == $past(en_req))
    else $error("state enable wrong");
  chk_save_copy: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !abort && save_req)
    |=> saved_enabled_out[$past(idx)] == cur_enabled_out[$past(idx)])
    else $error("save copy missing");
  chk_feature_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !extended_power_feature_in) |=> error_register_out[2])
    else $error("feature off not aborted");
  chk_save_abort: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && save_req && !cond_saveable_in[idx]) |=> error_register_out[2])
    else $error("bad save not aborted");
  // accepted command completes at a fixed distance
  chk_cmd_latency: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_IDLE && st_next.state == PCT_READ) |=> ##2 cmd_done_out)
    else $error("completion late");
  // 110 minutes and more overflow the 100 ms range
  chk_clamp_max: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && st_reg.secnum[`PCT_BIT_UNITS] && st_reg.timer > 16'h006d)
    |-> clamped == 16'hffff)
    else $error("clamp failed");
  chk_unit_plain: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !st_reg.secnum[`PCT_BIT_UNITS]) |-> clamped == st_reg.timer)
    else $error("plain units altered");
  // minute values scale exactly below the ceiling
  chk_unit_minute: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && st_reg.secnum[`PCT_BIT_UNITS] && st_reg.timer < 16'h006e)
    |-> ((clamped % `PCT_MIN_PER_UNIT) == 16'h0000)
    && ((clamped / `PCT_MIN_PER_UNIT) == st_reg.timer))
    else $error("minute scaling wrong");
  chk_idle_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_IDLE) |-> !status_register_out[`PCT_STS_BUSY_BIT])
    else $error("busy while idle");
  chk_busy_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_READ || st_reg.state == PCT_EXEC) |-> status_register_out[7])
    else $error("busy dropped early");
  // taking a command raises busy at once
  chk_busy_take: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_IDLE && st_next.state == PCT_READ)
    |=> status_register_out[7] && !cmd_done_out)
    else $error("busy not raised");
  // fault and unused error bits stay low
  chk_fault_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !status_register_out[`PCT_STS_FAULT_BIT] && ((error_register_out & 8'hfb) == 8'h00))
    else $error("stray fault or error bit");
  chk_done_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_done_out |=> !cmd_done_out)
    else $error("done held too long");
  chk_ok_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !abort)
    |=> !error_register_out[2] && !status_register_out[0])
    else $error("error left after success");
  // timer code is taken as timer-loading
  chk_decode_timer: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_IDLE && cmd_valid_in && command_in == 8'hef && feature_in == 8'h4a
    && sector_number_in[3:0] == 4'h2)
    |=> st_reg.state == PCT_READ && st_reg.is_timer)
    else $error("timer code not taken");
  // state code is taken as state-only
  chk_decode_state: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_IDLE && cmd_valid_in && command_in == 8'hef && feature_in == 8'h4a
    && sector_number_in[3:0] == 4'h3)
    |=> st_reg.state == PCT_READ && !st_reg.is_timer)
    else $error("state code not taken");
  // other subcommand codes are left alone
  chk_decode_other: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_IDLE && cmd_valid_in
    && sector_number_in[3:0] != 4'h2 && sector_number_in[3:0] != 4'h3)
    |=> st_reg.state == PCT_IDLE)
    else $error("foreign code taken");
  // a command while busy cannot replace the captured one
  chk_busy_refuse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_READ)
    |=> st_reg.state == PCT_EXEC && $stable(st_reg.cond) && $stable(st_reg.secnum))
    else $error("busy command overwritten");
  // only the named condition may change
  chk_one_cond: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC)
    |=> ((cur_enabled_out ^ $past(cur_enabled_out)) & ~(4'h1 << $past(idx))) == 4'h0)
    else $error("other condition changed");
  // non-zero timer with enable turns on
  chk_timer_enable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !abort && st_reg.is_timer && en_req && clamped != 16'h0000)
    |=> cur_enabled_out[$past(idx)])
    else $error("timer not enabled");
  chk_disable_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !abort && !en_req)
    |=> !cur_enabled_out[$past(idx)])
    else $error("disable ignored");
  chk_unchangeable: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && !cond_changeable_in[idx])
    |=> error_register_out[2])
    else $error("unchangeable not aborted");
  chk_unsupported: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (st_reg.state == PCT_EXEC && (st_reg.cond > 8'h03 || !cond_supported_in[idx]))
    |=> error_register_out[2])
    else $error("unsupported not aborted");
endmodule : pct_cmd

// >>> dv/pct_host_model.sv
`timescale 1ns/1ps
module pct_host_model
  import pct_pkg::*;
(
  // clock
  input  wire logic       core_clk_in,
  // task-file command block
  output      logic       cmd_valid_out,
  output      logic [7:0] command_out,
  output      logic [7:0] feature_out,
  output      logic [7:0] sector_count_out,
  output      logic [7:0] sector_number_out,
  output      logic [7:0] cylinder_low_out,
  output      logic [7:0] cylinder_high_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    {command_out, feature_out, sector_count_out} = '0;
    {sector_number_out, cylinder_high_out, cylinder_low_out} = '0;
  end

  // entered at a falling edge; fields stand for the one sampling cycle
  // command and feature codes as passed in by the caller
  task automatic send(input logic [7:0] cmd, input logic [7:0] feat, input logic [7:0] sc,
                      input logic [7:0] sn, input logic [15:0] tmr);
    cmd_valid_out = 1'b1;
    {command_out, feature_out, sector_count_out} = {cmd, feat, sc};
    {sector_number_out, cylinder_high_out, cylinder_low_out} = {sn, tmr};
    @(negedge core_clk_in);
    // released bytes flip so a stale value is never read as valid
    cmd_valid_out = 1'b0;
    {command_out, feature_out, sector_count_out} = ~{cmd, feat, sc};
    {sector_number_out, cylinder_high_out, cylinder_low_out} = ~{sn, tmr};
  endtask : send
endmodule : pct_host_model

// >>> dv/power_condition_timer_cmd_tb.sv
`timescale 1ns/1ps
`include "pct_defines.svh"
module power_condition_timer_cmd_tb
  import pct_pkg::*;
;
  logic       core_clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       cmd_valid_in;
  logic [7:0] command_in, feature_in, sector_count_in;
  logic [7:0] sector_number_in, cylinder_low_in, cylinder_high_in;
  logic       extended_power_feature_in = 1'b1;
  logic [3:0] cond_supported_in = 4'hf;
  logic [3:0] cond_changeable_in = 4'hf;
  logic [3:0] cond_saveable_in = 4'hf;
  logic       drive_ready_pin_in = 1'b1;
  logic [7:0] error_register_out, status_register_out;
  logic       cmd_done_out;
  logic [3:0] cur_enabled_out, saved_enabled_out;
  logic [3:0] m_cur = 4'h0;
  logic [3:0] m_sav = 4'h0;
  int         mismatches = 0;
  int         n_tests = 0;
  int         cycles = 0;
  logic [31:0] r;

  always #50 core_clk_in = ~core_clk_in;

  pct_host_model u_host (.core_clk_in, .cmd_valid_out(cmd_valid_in), .command_out(command_in),
    .feature_out(feature_in), .sector_count_out(sector_count_in),
    .sector_number_out(sector_number_in), .cylinder_low_out(cylinder_low_in),
    .cylinder_high_out(cylinder_high_in));

  pct_cmd u_dut (.core_clk_in, .rst_n_in, .cmd_valid_in, .command_in, .feature_in,
    .sector_count_in, .sector_number_in, .cylinder_low_in, .cylinder_high_in,
    .extended_power_feature_in, .cond_supported_in, .cond_changeable_in, .cond_saveable_in,
    .drive_ready_pin_in, .error_register_out, .status_register_out, .cmd_done_out,
    .cur_enabled_out, .saved_enabled_out);

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic abort_of(input logic [7:0] sc, input logic [7:0] sn);
    logic [1:0] i;
    i = sc[1:0];
    return !extended_power_feature_in || sc > 8'h03 || !cond_supported_in[i]
      || !cond_changeable_in[i] || (sn[4] && !cond_saveable_in[i]);
  endfunction : abort_of

  // issue at a falling edge; intr throws a second command at the busy device
  task automatic run(input logic [7:0] cmd, input logic [7:0] feat, input logic [7:0] sc,
                     input logic [7:0] sn, input logic [15:0] tmr, input logic intr);
    logic tk;
    logic ab;
    int   n;
    tk = cmd == 8'hef && feat == 8'h4a && sn[3:0] inside {4'h2, 4'h3};
    ab = abort_of(sc, sn);
    u_host.send(cmd, feat, sc, sn, tmr);
    if (tk) check(status_register_out[7], 1'b1);
    // a second command lands while busy and must be ignored
    if (intr)
    begin
      @(negedge core_clk_in);
      u_host.send(8'hef, 8'h4a, sc, {2'b00, ~sn[5], 5'h13}, 16'h0000);
    end
    n = 0;
    while (cmd_done_out !== 1'b1 && n < 8)
    begin
      @(negedge core_clk_in);
      n++;
    end
    check(cmd_done_out, tk);
    if (tk && !ab)
    begin
      m_cur[sc[1:0]] = sn[5] && (sn[3:0] == 4'h3 || tmr != 16'h0000);
      if (sn[4]) m_sav[sc[1:0]] = m_cur[sc[1:0]];
    end
    if (tk) check(error_register_out, ab ? 8'h04 : 8'h00);
    if (tk) check(status_register_out & 8'ha1, {7'h00, ab});
    if (tk) check(status_register_out[6], drive_ready_pin_in);
    check(cur_enabled_out, m_cur);
    check(saved_enabled_out, m_sav);
    // the cycle after done is still refused, so leave one idle edge
    @(negedge core_clk_in);
  endtask : run

  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    void'($urandom(2487));
    repeat (5) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    check({error_register_out, status_register_out & 8'he1}, 16'h0000);
    repeat (6) @(negedge core_clk_in);
    run(8'hef, 8'h4a, 8'h00, 8'h32, 16'h1234, 1'b0);
    run(8'hef, 8'h4a, 8'h00, 8'h22, 16'h0000, 1'b0);
    run(8'hef, 8'h4a, 8'h01, 8'hb2, 16'hffff, 1'b1);
    run(8'hef, 8'h4a, 8'h01, 8'h13, 16'h0000, 1'b0);
    run(8'hef, 8'h4a, 8'h02, 8'ha2, 16'h0005, 1'b0);
    foreach (r[k])
      if (k < 6) run(k[1] ? 8'hec : 8'hef, k[0] ? 8'h4b : 8'h4a, 8'h02, 8'h30 | 8'(k), 16'h0001, 1'b0);
    cond_saveable_in = 4'h7;
    run(8'hef, 8'h4a, 8'h03, 8'h32, 16'h0005, 1'b0);
    run(8'hef, 8'h4a, 8'h03, 8'h33, 16'h0000, 1'b0);
    run(8'hef, 8'h4a, 8'h04, 8'h23, 16'h0000, 1'b0);
    cond_changeable_in = 4'hb;
    run(8'hef, 8'h4a, 8'h02, 8'h22, 16'h0009, 1'b0);
    extended_power_feature_in = 1'b0;
    drive_ready_pin_in = 1'b0;
    repeat (6) @(negedge core_clk_in);
    run(8'hef, 8'h4a, 8'h00, 8'h23, 16'h0000, 1'b0);
    drive_ready_pin_in = 1'b1;
    repeat (6) @(negedge core_clk_in);
    repeat (150)
    begin
      r = $urandom;
      cond_supported_in = 4'($urandom | $urandom);
      cond_changeable_in = 4'($urandom | $urandom);
      cond_saveable_in = 4'($urandom);
      extended_power_feature_in = 1'($urandom % 8 != 0);
      run(8'hef, 8'h4a, 8'(r[10:8] % 5), {r[7:4], 3'b001, r[0]},
          r[12:11] == 2'b00 ? 16'h0000 : r[31:16], r[2] & r[3]);
    end
    rst_n_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    m_cur = 4'h0;
    m_sav = 4'h0;
    check({cur_enabled_out, saved_enabled_out}, 16'h0000);
    test_done();
  end
endmodule : power_condition_timer_cmd_tb
